// ===== inc/pin_select_regs.vh
// Purpose : Offsets, field layout, reset values for the pin selectors
// Assumes : 16-bit register port, byte offsets on 16-bit boundaries
// Notes   : Included by the selector top and the pin decoder
`ifndef PIN_SELECT_REGS_VH
`define PIN_SELECT_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_W              4
`define PORT_D_OFFSET       4'h0
`define PORT_E_OFFSET       4'h2
`define PORT_F_OFFSET       4'h4
`define SELECT_STATUS_OFFSET 4'h6

// ----------------------------------------------------------------------
// Field layout and codes
// ----------------------------------------------------------------------
`define DATA_W              16
`define PINS                8
`define MODE_W              2
`define MODE_PERIPH         2'h0
`define MODE_OUTPUT         2'h1
`define MODE_IN_PULL        2'h2
`define MODE_IN_FLOAT       2'h3

// ----------------------------------------------------------------------
// Power-on reset values
// ----------------------------------------------------------------------
`define PORT_D_RESET        16'haa8a
`define PORT_E_RESET_HI     16'haaaa
`define PORT_E_RESET_LO     16'h2aa8
`define PORT_F_RESET_HI     16'haaaa
`define PORT_F_RESET_LO     16'h00aa

// ----------------------------------------------------------------------
// Per-port capability masks, one bit per pin
// ----------------------------------------------------------------------
`define PORT_D_PERIPH_MASK  8'hff
`define PORT_D_OUTPUT_MASK  8'haf
`define PORT_E_PERIPH_MASK  8'h34
`define PORT_E_OUTPUT_MASK  8'hff
`define PORT_F_PERIPH_MASK  8'hff
`define PORT_F_OUTPUT_MASK  8'h00

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define STAT_STRAP_BIT      0
`define STAT_INIT_BIT       1
`define STAT_RSVD_D_BIT     4
`define STAT_RSVD_E_BIT     5
`define STAT_RSVD_F_BIT     6

`endif

// ===== hdl/pin_mode_decode.v
// Purpose : Decode one 8-pin selector word and steer the pins
// Assumes : Pin and peripheral signals synchronous to the system clock
// Notes   : Reserved codes leave the pin undriven with no pull-up
`timescale 1ns/1ps
`include "pin_select_regs.vh"

module pin_mode_decode #(
  parameter [7:0] PERIPH_MASK = 8'hff,
  parameter [7:0] OUTPUT_MASK = 8'hff
) (
  input  wire [15:0] select_word,
  input  wire [7:0]  pin_i,
  output wire [7:0]  pin_o,
  output wire [7:0]  pin_oe,
  output wire [7:0]  pin_pull_up,
  input  wire [7:0]  periph_o,
  input  wire [7:0]  periph_oe,
  output wire [7:0]  periph_i,
  input  wire [7:0]  port_out_data,
  output wire [7:0]  port_in_data,
  output wire [7:0]  reserved_sel
);

  // --------------------------------------------------------------------
  // Per-pin decode
  // --------------------------------------------------------------------
  genvar n;
  generate
    for (n = 0; n < `PINS; n = n + 1) begin : g_pin
      wire [1:0] mode;
      wire       sel_periph;
      wire       sel_out;
      assign mode = select_word[2*n+1:2*n];
      // Code 00 is a peripheral only where the pin has one
      assign sel_periph = (mode == `MODE_PERIPH) && PERIPH_MASK[n];
      // Code 01 is reserved on pins without a port output
      assign sel_out = (mode == `MODE_OUTPUT) && OUTPUT_MASK[n];
      assign reserved_sel[n] = ((mode == `MODE_PERIPH) && !PERIPH_MASK[n])
                             | ((mode == `MODE_OUTPUT) && !OUTPUT_MASK[n]);
      assign pin_o[n] = sel_periph ? periph_o[n] : port_out_data[n];
      assign pin_oe[n] = sel_periph ? periph_oe[n] : sel_out;
      assign pin_pull_up[n] = (mode == `MODE_IN_PULL);
      // Peripheral sees a quiet low unless it owns the pin
      assign periph_i[n] = sel_periph ? pin_i[n] : 1'b0;
      // Port read always shows the pin level, also in output mode
      assign port_in_data[n] = pin_i[n];
    end
  endgenerate

endmodule

// ===== hdl/pin_select.v
// Function
// - Port D selector: 16-bit RW, resets aa8a
// - Only power-on reset reloads selector registers
// - Port D fields: periph, output, pull, float
// - Port D pin2 periph, others pull-up at reset
// - Port D pins 4,6: 01 reserved, pull-up reset
// - Port E resets aaaa strap high, 2aa8 low
// - Port E pins 0,7: 00 reserved/debug
// - Port E pins 1-6: periph on 2,4,5
// - Port F resets aaaa strap high, 00aa low
// - Port F pins 4-7: 00 periph, strap reset
// - Port F pins 0-3 reset to pull-up always
//
// Purpose : Pin function selectors for ports D, E and F
// Assumes : nrst is the power-on reset; strap stable around its release
// Notes   : Strap-dependent values load on the first edge after release
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "pin_select_regs.vh"

module pin_select (
  clk_sys,
  nrst,
  debug_mode_strap,
  addr,
  wr_data,
  wr_en,
  rd_en,
  rd_data,
  pin_d_i,
  pin_d_o,
  pin_d_oe,
  pin_d_pull_up,
  periph_d_o,
  periph_d_oe,
  periph_d_i,
  port_d_out_data,
  port_d_in_data,
  pin_e_i,
  pin_e_o,
  pin_e_oe,
  pin_e_pull_up,
  periph_e_o,
  periph_e_oe,
  periph_e_i,
  port_e_out_data,
  port_e_in_data,
  pin_f_i,
  pin_f_o,
  pin_f_oe,
  pin_f_pull_up,
  periph_f_o,
  periph_f_oe,
  periph_f_i,
  port_f_out_data,
  port_f_in_data
);

  // --------------------------------------------------------------------
  // Ports
  // --------------------------------------------------------------------
  input  wire                clk_sys;
  input  wire                nrst;
  input  wire                debug_mode_strap;
  input  wire [`ADDR_W-1:0]  addr;
  input  wire [`DATA_W-1:0]  wr_data;
  input  wire                wr_en;
  input  wire                rd_en;
  output reg  [`DATA_W-1:0]  rd_data;
  input  wire [7:0]          pin_d_i;
  output wire [7:0]          pin_d_o;
  output wire [7:0]          pin_d_oe;
  output wire [7:0]          pin_d_pull_up;
  input  wire [7:0]          periph_d_o;
  input  wire [7:0]          periph_d_oe;
  output wire [7:0]          periph_d_i;
  input  wire [7:0]          port_d_out_data;
  output wire [7:0]          port_d_in_data;
  input  wire [7:0]          pin_e_i;
  output wire [7:0]          pin_e_o;
  output wire [7:0]          pin_e_oe;
  output wire [7:0]          pin_e_pull_up;
  input  wire [7:0]          periph_e_o;
  input  wire [7:0]          periph_e_oe;
  output wire [7:0]          periph_e_i;
  input  wire [7:0]          port_e_out_data;
  output wire [7:0]          port_e_in_data;
  input  wire [7:0]          pin_f_i;
  output wire [7:0]          pin_f_o;
  output wire [7:0]          pin_f_oe;
  output wire [7:0]          pin_f_pull_up;
  input  wire [7:0]          periph_f_o;
  input  wire [7:0]          periph_f_oe;
  output wire [7:0]          periph_f_i;
  input  wire [7:0]          port_f_out_data;
  output wire [7:0]          port_f_in_data;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  function hit;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] offset;
    begin
      hit = (a == offset);
    end
  endfunction

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  reg  [`DATA_W-1:0] port_d_pin_select_reg;
  reg  [`DATA_W-1:0] port_d_pin_select_next;
  reg  [`DATA_W-1:0] port_e_pin_select_reg;
  reg  [`DATA_W-1:0] port_e_pin_select_next;
  reg  [`DATA_W-1:0] port_f_pin_select_reg;
  reg  [`DATA_W-1:0] port_f_pin_select_next;
  reg                init_done_reg;
  reg                strap_reg;
  reg                strap_next;
  reg  [`DATA_W-1:0] rd_data_next;
  wire [7:0]         rsvd_d;
  wire [7:0]         rsvd_e;
  wire [7:0]         rsvd_f;
  wire [`DATA_W-1:0] status_word;
  wire               wr_d;
  wire               wr_e;
  wire               wr_f;

  // Writes before the strap load are dropped, not held until it is done
  assign wr_d = wr_en && init_done_reg && hit(addr, `PORT_D_OFFSET);
  assign wr_e = wr_en && init_done_reg && hit(addr, `PORT_E_OFFSET);
  assign wr_f = wr_en && init_done_reg && hit(addr, `PORT_F_OFFSET);

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------
  always @* begin
    port_d_pin_select_next = port_d_pin_select_reg;
    port_e_pin_select_next = port_e_pin_select_reg;
    port_f_pin_select_next = port_f_pin_select_reg;
    strap_next = strap_reg;
    if (!init_done_reg) begin
      // Strap is held by the board through reset, sampled at release
      strap_next = debug_mode_strap;
      port_e_pin_select_next = debug_mode_strap ?
        `PORT_E_RESET_HI : `PORT_E_RESET_LO;
      port_f_pin_select_next = debug_mode_strap ?
        `PORT_F_RESET_HI : `PORT_F_RESET_LO;
    end
    // Reserved codes are stored as written; decoding makes them inert
    if (wr_d) begin
      port_d_pin_select_next = wr_data;
    end
    if (wr_e) begin
      port_e_pin_select_next = wr_data;
    end
    if (wr_f) begin
      port_f_pin_select_next = wr_data;
    end
  end

  // --------------------------------------------------------------------
  // Selector registers
  // --------------------------------------------------------------------
  // Only the power-on reset clears these; no other reset reaches them
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      port_d_pin_select_reg <= `PORT_D_RESET;
      port_e_pin_select_reg <= `PORT_E_RESET_HI;
      port_f_pin_select_reg <= `PORT_F_RESET_HI;
      strap_reg <= 1'b1;
      init_done_reg <= 1'b0;
    end else begin
      port_d_pin_select_reg <= port_d_pin_select_next;
      port_e_pin_select_reg <= port_e_pin_select_next;
      port_f_pin_select_reg <= port_f_pin_select_next;
      strap_reg <= strap_next;
      init_done_reg <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Status word
  // --------------------------------------------------------------------
  assign status_word = {9'h000,
                        |rsvd_f,
                        |rsvd_e,
                        |rsvd_d,
                        2'h0,
                        init_done_reg,
                        strap_reg};

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  always @* begin
    rd_data_next = 16'h0000;
    if (rd_en) begin
      if (hit(addr, `PORT_D_OFFSET)) begin
        rd_data_next = port_d_pin_select_reg;
      end else if (hit(addr, `PORT_E_OFFSET)) begin
        rd_data_next = port_e_pin_select_reg;
      end else if (hit(addr, `PORT_F_OFFSET)) begin
        rd_data_next = port_f_pin_select_reg;
      end else if (hit(addr, `SELECT_STATUS_OFFSET)) begin
        rd_data_next = status_word;
      end else begin
        rd_data_next = 16'h0000;
      end
    end
  end

  // Read data stand for one cycle only, zero otherwise
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rd_data <= 16'h0000;
    end else begin
      rd_data <= rd_data_next;
    end
  end

  // --------------------------------------------------------------------
  // Port D pins
  // --------------------------------------------------------------------
  // Pins 4 and 6 have no port output, so code 01 is reserved there
  pin_mode_decode #(
    .PERIPH_MASK (`PORT_D_PERIPH_MASK),
    .OUTPUT_MASK (`PORT_D_OUTPUT_MASK)
  ) u_port_d (
    .select_word   (port_d_pin_select_reg),
    .pin_i         (pin_d_i),
    .pin_o         (pin_d_o),
    .pin_oe        (pin_d_oe),
    .pin_pull_up   (pin_d_pull_up),
    .periph_o      (periph_d_o),
    .periph_oe     (periph_d_oe),
    .periph_i      (periph_d_i),
    .port_out_data (port_d_out_data),
    .port_in_data  (port_d_in_data),
    .reserved_sel  (rsvd_d)
  );

  // --------------------------------------------------------------------
  // Port E pins
  // --------------------------------------------------------------------
  // Code 00 on pins 0 and 7 is the debug setting, no peripheral here
  pin_mode_decode #(
    .PERIPH_MASK (`PORT_E_PERIPH_MASK),
    .OUTPUT_MASK (`PORT_E_OUTPUT_MASK)
  ) u_port_e (
    .select_word   (port_e_pin_select_reg),
    .pin_i         (pin_e_i),
    .pin_o         (pin_e_o),
    .pin_oe        (pin_e_oe),
    .pin_pull_up   (pin_e_pull_up),
    .periph_o      (periph_e_o),
    .periph_oe     (periph_e_oe),
    .periph_i      (periph_e_i),
    .port_out_data (port_e_out_data),
    .port_in_data  (port_e_in_data),
    .reserved_sel  (rsvd_e)
  );

  // --------------------------------------------------------------------
  // Port F pins
  // --------------------------------------------------------------------
  // Port F is input-only as a port: code 01 is reserved on every pin
  pin_mode_decode #(
    .PERIPH_MASK (`PORT_F_PERIPH_MASK),
    .OUTPUT_MASK (`PORT_F_OUTPUT_MASK)
  ) u_port_f (
    .select_word   (port_f_pin_select_reg),
    .pin_i         (pin_f_i),
    .pin_o         (pin_f_o),
    .pin_oe        (pin_f_oe),
    .pin_pull_up   (pin_f_pull_up),
    .periph_o      (periph_f_o),
    .periph_oe     (periph_f_oe),
    .periph_i      (periph_f_i),
    .port_out_data (port_f_out_data),
    .port_in_data  (port_f_in_data),
    .reserved_sel  (rsvd_f)
  );

endmodule

// ===== sim/pad_model.sv
// Purpose : Package pads of one 8-pin port with their outside load
// Assumes : Pull-up acts only where the selector turns it on
// Notes   : A pad neither driven nor pulled shows the inverse of pin_o,
//           so a lost enable never reads back as a plausible level
`timescale 1ns/1ps
module pad_model (
  input  wire [7:0] pin_o,
  input  wire [7:0] pin_oe,
  input  wire [7:0] pin_pull_up,
  output wire [7:0] pin_i
);
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & (pin_pull_up | ~pin_o));
endmodule

// ===== sim/pin_select_sva.sv
// Purpose : Port checks for the pin selectors
// Assumes : nrst is the only reset of the selectors
// Notes   : Shadow copies of the selectors follow the bus writes
`timescale 1ns/1ps
`include "pin_select_regs.vh"
module pin_select_chk (
  input wire        clk_sys,
  input wire        nrst,
  input wire        debug_mode_strap,
  input wire [3:0]  addr,
  input wire [15:0] wr_data,
  input wire        wr_en,
  input wire        rd_en,
  input wire [15:0] rd_data,
  input wire [7:0]  pin_d_oe,
  input wire [7:0]  pin_d_pull_up,
  input wire [7:0]  periph_d_oe,
  input wire [7:0]  pin_e_oe,
  input wire [7:0]  periph_e_oe,
  input wire [7:0]  pin_f_oe,
  input wire [7:0]  pin_f_pull_up,
  input wire [7:0]  periph_f_oe
);
  reg        up_reg;
  reg [15:0] d_reg, e_reg, f_reg;
  // Expected enables; absent functions and reserved codes stay undriven
  function automatic [7:0] oe_f(input [15:0] s, input [7:0] p,
                                input [7:0] pm, input [7:0] om);
    integer n;
    for (n = 0; n < 8; n = n + 1)
      oe_f[n] = (s[2*n+:2] == 2'h0) ? p[n] & pm[n]
                                    : (s[2*n+:2] == 2'h1) & om[n];
  endfunction
  function automatic [7:0] pu_f(input [15:0] s);
    integer n;
    for (n = 0; n < 8; n = n + 1)
      pu_f[n] = s[2*n+:2] == 2'h2;
  endfunction
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      up_reg <= 1'b0;
      d_reg <= 16'haa8a;
      e_reg <= 16'haaaa;
      f_reg <= 16'haaaa;
    end else if (!up_reg) begin
      up_reg <= 1'b1;
      e_reg <= debug_mode_strap ? 16'haaaa : 16'h2aa8;
      f_reg <= debug_mode_strap ? 16'haaaa : 16'h00aa;
    end else if (wr_en) begin
      if (addr == `PORT_D_OFFSET) d_reg <= wr_data;
      if (addr == `PORT_E_OFFSET) e_reg <= wr_data;
      if (addr == `PORT_F_OFFSET) f_reg <= wr_data;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_rd_idle; !$past(rd_en) |-> rd_data == 16'h0; endproperty
  property p_rd_d;
    rd_en && addr == `PORT_D_OFFSET |=> rd_data == $past(d_reg);
  endproperty
  property p_rd_e;
    rd_en && addr == `PORT_E_OFFSET |=> rd_data == $past(e_reg);
  endproperty
  property p_rd_f;
    rd_en && addr == `PORT_F_OFFSET |=> rd_data == $past(f_reg);
  endproperty
  property p_d_oe;
    pin_d_oe == oe_f(d_reg, periph_d_oe, 8'hff, 8'haf);
  endproperty
  property p_d_pu; pin_d_pull_up == pu_f(d_reg); endproperty
  property p_e_oe;
    pin_e_oe == oe_f(e_reg, periph_e_oe, 8'h34, 8'hff);
  endproperty
  property p_f_oe;
    pin_f_oe == oe_f(f_reg, periph_f_oe, 8'hff, 8'h00);
  endproperty
  property p_f_pu; pin_f_pull_up == pu_f(f_reg); endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rd_data not idle");
  a_rd_d: assert property (p_rd_d) else $error("port D readback");
  a_rd_e: assert property (p_rd_e) else $error("port E readback");
  a_rd_f: assert property (p_rd_f) else $error("port F readback");
  a_d_oe: assert property (p_d_oe) else $error("port D enable");
  a_d_pu: assert property (p_d_pu) else $error("port D pull-up");
  a_e_oe: assert property (p_e_oe) else $error("port E enable");
  a_f_oe: assert property (p_f_oe) else $error("port F enable");
  a_f_pu: assert property (p_f_pu) else $error("port F pull-up");
  c_wr_d: cover property (wr_en && addr == `PORT_D_OFFSET);
  c_rd_e: cover property (rd_en && addr == `PORT_E_OFFSET);
  c_low: cover property (!up_reg && !debug_mode_strap);
endmodule
bind pin_select pin_select_chk pin_select_chk_inst (
  .clk_sys, .nrst, .debug_mode_strap, .addr, .wr_data, .wr_en, .rd_en,
  .rd_data, .pin_d_oe, .pin_d_pull_up, .periph_d_oe, .pin_e_oe,
  .periph_e_oe, .pin_f_oe, .pin_f_pull_up, .periph_f_oe
);

// ===== sim/tb.sv
// Purpose : Self-checking bench for the pin selectors
// Assumes : One peripheral drive pattern shared by all three ports
// Notes   : Expected values come from the documented codes and resets
`timescale 1ns/1ps
`include "pin_select_regs.vh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
  miscompares++; $display("CHECK FAILED t=%0t got %h exp %h", \
  $time, a, e); end end
module tb;
  reg         clk_sys, nrst, debug_mode_strap, wr_en, rd_en;
  reg  [3:0]  addr;
  reg  [15:0] wr_data;
  reg  [7:0]  po, poe, pod;
  wire [15:0] rd_data;
  wire [7:0]  pin_d_i, pin_d_o, pin_d_oe, pin_d_pull_up, periph_d_i;
  wire [7:0]  pin_e_i, pin_e_o, pin_e_oe, pin_e_pull_up, periph_e_i;
  wire [7:0]  pin_f_i, pin_f_o, pin_f_oe, pin_f_pull_up, periph_f_i;
  wire [7:0]  port_d_in_data, port_e_in_data, port_f_in_data;
  integer     miscompares = 0, checks_done = 0, cyc = 0, c;
  pin_select pin_select_inst (
    .clk_sys, .nrst, .debug_mode_strap, .addr, .wr_data, .wr_en, .rd_en,
    .rd_data, .pin_d_i, .pin_d_o, .pin_d_oe, .pin_d_pull_up, .periph_d_i,
    .port_d_in_data, .pin_e_i, .pin_e_o, .pin_e_oe, .pin_e_pull_up,
    .periph_e_i, .port_e_in_data, .pin_f_i, .pin_f_o, .pin_f_oe,
    .pin_f_pull_up, .periph_f_i, .port_f_in_data,
    .periph_d_o(po), .periph_d_oe(poe), .port_d_out_data(pod),
    .periph_e_o(po), .periph_e_oe(poe), .port_e_out_data(pod),
    .periph_f_o(po), .periph_f_oe(poe), .port_f_out_data(pod));
  pad_model pad_model_inst [2:0] (
    .pin_o({pin_f_o, pin_e_o, pin_d_o}),
    .pin_oe({pin_f_oe, pin_e_oe, pin_d_oe}),
    .pin_pull_up({pin_f_pull_up, pin_e_pull_up, pin_d_pull_up}),
    .pin_i({pin_f_i, pin_e_i, pin_d_i}));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task wr(input [3:0] a, input [15:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    rd_en <= 1'b0;
    @(posedge clk_sys);
  endtask
  task rd(input [3:0] a, input [15:0] e);
    addr <= a;
    rd_en <= 1'b1;
    wr_en <= 1'b0;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(negedge clk_sys);
    `CHK(rd_data, e)
    @(posedge clk_sys);
  endtask
  task settle;
    wr_en <= 1'b0;
    @(negedge clk_sys);
  endtask
  task por(input s);
    nrst <= 1'b0;
    debug_mode_strap <= s;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd(`PORT_D_OFFSET, 16'haa8a);
    rd(`PORT_E_OFFSET, s ? 16'haaaa : 16'h2aa8);
    rd(`PORT_F_OFFSET, s ? 16'haaaa : 16'h00aa);
    rd(`SELECT_STATUS_OFFSET, s ? 16'h0003 : 16'h0022);
    settle;
    `CHK(pin_e_oe, 8'h00)
    `CHK(pin_f_oe, s ? 8'h00 : poe & 8'hf0)
    `CHK(pin_d_o[2], po[2])
    `CHK(pin_d_pull_up, 8'hfb)
    `CHK(pin_e_pull_up, s ? 8'hff : 8'h7e)
    `CHK(pin_f_pull_up, s ? 8'hff : 8'h0f)
    @(posedge clk_sys);
  endtask
  // Back-to-back access, then unmapped and status writes must not stick
  task walk;
    wr(`PORT_D_OFFSET, 16'h5555);
    rd(`PORT_D_OFFSET, 16'h5555);
    wr(4'h8, 16'h1234);
    wr(`SELECT_STATUS_OFFSET, 16'hffff);
    rd(`SELECT_STATUS_OFFSET, 16'h0013);
    rd(4'h8, 16'h0000);
    repeat (40) @(posedge clk_sys);
    rd(`PORT_D_OFFSET, 16'h5555);
  endtask
  // Every code on every pin; code 01 also lands on reserved pins
  task modes;
    for (c = 0; c < 4; c++) begin
      wr(`PORT_D_OFFSET, {8{c[1:0]}});
      wr(`PORT_E_OFFSET, {8{c[1:0]}});
      wr(`PORT_F_OFFSET, {8{c[1:0]}});
      settle;
      `CHK(pin_d_oe, c == 0 ? poe : c == 1 ? 8'haf : 8'h00)
      `CHK(pin_d_o & pin_d_oe, c == 0 ? po & poe : c == 1 ? pod & 8'haf
           : 8'h00)
      `CHK(pin_d_pull_up, c == 2 ? 8'hff : 8'h00)
      `CHK(port_d_in_data, c == 2 ? 8'hff : pin_d_i)
      `CHK(periph_d_i, c == 0 ? pin_d_i : 8'h00)
      `CHK(pin_e_oe, c == 0 ? poe & 8'h34 : c == 1 ? 8'hff : 8'h00)
      `CHK(pin_f_oe, c == 0 ? poe : 8'h00)
      `CHK(pin_f_pull_up, c == 2 ? 8'hff : 8'h00)
      `CHK(pin_e_pull_up, c == 2 ? 8'hff : 8'h00)
      `CHK(periph_e_i, c == 0 ? pin_e_i & 8'h34 : 8'h00)
      `CHK(periph_f_i, c == 0 ? pin_f_i : 8'h00)
      `CHK(port_e_in_data, c == 2 ? 8'hff : pin_e_i)
      `CHK(port_f_in_data, c == 2 ? 8'hff : pin_f_i)
      `CHK(pin_e_o, c == 0 ? po & 8'h34 | pod & 8'hcb : pod)
      `CHK(pin_f_o, c == 0 ? po : pod)
      @(posedge clk_sys);
    end
  endtask
  task complete_run;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      complete_run;
    end
  end
  initial begin
    nrst = 1'b0;
    debug_mode_strap = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 4'h0;
    wr_data = 16'h0000;
    po = 8'h3c;
    poe = 8'h5a;
    pod = 8'hc3;
    por(1'b1);
    walk;
    modes;
    por(1'b0);
    modes;
    por(1'b1);
    complete_run;
  end
endmodule
